// [dtc_pkg.sv]
// Summary of operation
// - Overflow flag set by hardware, cleared on vectoring
// - Run bit starts and stops each timer
// - External flag set by edge/level, level tracks pin
// - Type bit picks falling edge or low level
// - Gate: count only while pin high and run
// - Counter select: count falling edges of pin
// - Mode 00: 8-bit counter with 5-bit prescaler
// - Mode 01: full 16-bit counter, no prescale
// - Mode 10: low byte reloads from high byte
// - Mode 11: timer 0 split, high uses timer 1 controls
// - Timer 1 in mode 11 stops and holds
// - Clock select: one divides by 4, zero by 12
// - Watchdog interval code exported, reset 512 longer
// - Stretch field resets to one, access stretch+2 cycles
// - On-chip SRAM accesses always two machine cycles
// - Count bytes readable and writable separately
// - Control register bit-addressable, unmapped addresses read all ones
package dtc_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] DTC_ADDR_CTRL  = 8'h88; // Run and flag register
	localparam logic [7:0] DTC_ADDR_MODE  = 8'h89; // Timer mode register
	localparam logic [7:0] DTC_ADDR_CL0   = 8'h8a; // Count 0 low byte
	localparam logic [7:0] DTC_ADDR_CL1   = 8'h8b; // Count 1 low byte
	localparam logic [7:0] DTC_ADDR_CH0   = 8'h8c; // Count 0 high byte
	localparam logic [7:0] DTC_ADDR_CH1   = 8'h8d; // Count 1 high byte
	localparam logic [7:0] DTC_ADDR_CKDIV = 8'h8e; // Clock divide select

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DTC_CTRL_OVF_B  = 7; // ovf_flag_b
	localparam int DTC_CTRL_RUN_B  = 6; // run_bit_b
	localparam int DTC_CTRL_OVF_A  = 5; // ovf_flag_a
	localparam int DTC_CTRL_RUN_A  = 4; // run_bit_a
	localparam int DTC_CTRL_EIF_B  = 3; // ext_irq_flag_b
	localparam int DTC_CTRL_EIT_B  = 2; // ext_irq_type_b
	localparam int DTC_CTRL_EIF_A  = 1; // ext_irq_flag_a
	localparam int DTC_CTRL_EIT_A  = 0; // ext_irq_type_a
	localparam int DTC_MODE_GATE   = 3; // Gate bit within each nibble
	localparam int DTC_MODE_CNT    = 2; // Counter select within nibble
	localparam int DTC_CK_WD_LO    = 6; // Watchdog interval code
	localparam int DTC_CK_SEL_C    = 5; // clk_div_sel_c
	localparam int DTC_CK_SEL_B    = 4; // clk_div_sel_b
	localparam int DTC_CK_SEL_A    = 3; // clk_div_sel_a
	localparam int DTC_CK_STR_LO   = 0; // Stretch field

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] DTC_CKDIV_RST  = 8'h01; // Stretch of one
	localparam logic [3:0] DTC_DIV_FAST   = 4'h4;  // Divide by 4
	localparam logic [3:0] DTC_DIV_SLOW   = 4'hc;  // Divide by 12
	localparam logic [4:0] DTC_PRESC_MAX  = 5'h1f; // Prescaler wrap
	localparam logic [3:0] DTC_MC_BASE    = 4'h2;  // Minimum access cycles
	localparam int         DTC_WD_EXTRA   = 512;   // Reset after interrupt

	// Operating modes
	typedef enum logic [1:0] {
		DTC_M13, DTC_M16, DTC_MRELOAD, DTC_MSPLIT
	} dtc_mode_e;

endpackage : dtc_pkg

// [dtc_tick.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Count clock divider: one tick every 4 or 12 clocks
// ----------------------------------------------------------------
module dtc_tick
	import dtc_pkg::*;
(
	input  wire logic clk,      // Core clock
	input  wire logic nrst,     // Async reset, active low
	input  wire logic ce,       // Clock enable
	input  wire logic sel_fast, // One selects divide by 4
	output logic      tick      // One-cycle count pulse
);
	typedef struct packed {
		logic [3:0] cnt; // Cycle counter
	} dtc_tick_s;

	dtc_tick_s st_q, st_d;
	logic [3:0] div;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		div  = sel_fast ? DTC_DIV_FAST : DTC_DIV_SLOW;
		tick = ce && (st_q.cnt >= div - 4'h1);
		if (tick)
			st_d.cnt = 4'h0;
		else if (ce)
			st_d.cnt = st_q.cnt + 4'h1;
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule : dtc_tick

// [dtc_core.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Dual timer/counter with external interrupt flags
// ----------------------------------------------------------------
module dtc_core (
	input  wire logic       clk,           // Core clock, 125 MHz
	input  wire logic       nrst,          // Async reset, active low
	input  wire logic       ce,            // Clock enable, freezes state
	input  wire logic [7:0] reg_addr,      // Direct register address
	input  wire logic       reg_wr,        // Byte write strobe
	input  wire logic       reg_rd,        // Byte read strobe
	input  wire logic [7:0] reg_wdata,     // Write data
	output logic      [7:0] reg_rdata,     // Read data, registered
	input  wire logic       bit_wr,        // Single-bit write strobe
	input  wire logic [2:0] bit_sel,       // Bit index in control register
	input  wire logic       bit_val,       // Value for bit write
	input  wire logic       ext_irq_pin_a, // External interrupt pin 0
	input  wire logic       ext_irq_pin_b, // External interrupt pin 1
	input  wire logic       cnt_pin_a,     // External count pin 0
	input  wire logic       cnt_pin_b,     // External count pin 1
	input  wire logic       vec_ovf_a,     // Vectoring to timer 0 service
	input  wire logic       vec_ovf_b,     // Vectoring to timer 1 service
	input  wire logic       vec_ext_a,     // Vectoring to ext interrupt 0
	input  wire logic       vec_ext_b,     // Vectoring to ext interrupt 1
	input  wire logic       xram_onchip,   // Access targets on-chip SRAM
	output logic            ovf_flag_a,    // Timer 0 overflow flag
	output logic            ovf_flag_b,    // Timer 1 overflow flag
	output logic            ext_irq_flag_a,// External flag 0
	output logic            ext_irq_flag_b,// External flag 1
	output logic      [1:0] wdog_interval, // Watchdog interval code
	output logic            clk_div_sel_c, // Timer 2 divide select
	output logic      [3:0] movx_cycles    // Access length in machine cycles
);
	import dtc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;     // Run and flag register
		logic [7:0] mode;     // Timer mode register
		logic [7:0] cl0;      // Count 0 low
		logic [7:0] cl1;      // Count 1 low
		logic [7:0] ch0;      // Count 0 high
		logic [7:0] ch1;      // Count 1 high
		logic [7:0] ckdiv;    // Clock divide select
		logic [1:0] pin_eip;  // Previous ext pins
		logic [1:0] pin_cnt;  // Previous count pins
		logic [7:0] rdata;    // Read data register
	} dtc_core_s;

	dtc_core_s st_q, st_d;
	logic tick_a, tick_b;                // Internal count ticks
	logic en_a, en_b;                    // Timer enables
	logic inc_a, inc_b, inc_hsplit;      // Count events
	logic ovf_a, ovf_b;                  // Overflow events this cycle
	logic [1:0] ext_pin, cnt_pin;
	logic [1:0] ext_set;
	dtc_mode_e md_a, md_b;

	// ----------------------------------------------------------------
	// Count clock dividers
	// ----------------------------------------------------------------
	dtc_tick u_tick_a (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.sel_fast (st_q.ckdiv[DTC_CK_SEL_A]),
		.tick     (tick_a)
	);
	dtc_tick u_tick_b (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.sel_fast (st_q.ckdiv[DTC_CK_SEL_B]),
		.tick     (tick_b)
	);

	// ----------------------------------------------------------------
	// Count event selection
	// ----------------------------------------------------------------
	always_comb begin
		ext_pin = {ext_irq_pin_b, ext_irq_pin_a};
		cnt_pin = {cnt_pin_b, cnt_pin_a};
		md_a    = dtc_mode_e'(st_q.mode[1:0]);
		md_b    = dtc_mode_e'(st_q.mode[5:4]);
		// Gate means run and pin high, otherwise run alone
		en_a = st_q.ctrl[DTC_CTRL_RUN_A] &&
			(!st_q.mode[DTC_MODE_GATE] || ext_pin[0]);
		en_b = st_q.ctrl[DTC_CTRL_RUN_B] &&
			(!st_q.mode[4 + DTC_MODE_GATE] || ext_pin[1]);
		// Counter mode takes falling pin edges, timer mode the ticks
		inc_a = ce && en_a && (st_q.mode[DTC_MODE_CNT]
			? (st_q.pin_cnt[0] && !cnt_pin[0]) : tick_a);
		inc_b = ce && en_b && (st_q.mode[4 + DTC_MODE_CNT]
			? (st_q.pin_cnt[1] && !cnt_pin[1]) : tick_b);
		// Split high half is a timer under timer 1 run bit only
		inc_hsplit = ce && (md_a == DTC_MSPLIT) &&
			st_q.ctrl[DTC_CTRL_RUN_B] && tick_a;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d  = st_q;
		ovf_a = 1'b0;
		ovf_b = 1'b0;

		// Register writes first so hardware events below win
		if (ce && reg_wr) begin
			case (reg_addr)
				DTC_ADDR_CTRL:  st_d.ctrl  = reg_wdata;
				DTC_ADDR_MODE:  st_d.mode  = reg_wdata;
				DTC_ADDR_CL0:   st_d.cl0   = reg_wdata;
				DTC_ADDR_CL1:   st_d.cl1   = reg_wdata;
				DTC_ADDR_CH0:   st_d.ch0   = reg_wdata;
				DTC_ADDR_CH1:   st_d.ch1   = reg_wdata;
				DTC_ADDR_CKDIV: st_d.ckdiv = reg_wdata;
				default: ;
			endcase
		end
		if (ce && bit_wr)
			st_d.ctrl[bit_sel] = bit_val;

		// Vectoring clears; overflow flags always, ext only in edge mode
		if (ce && vec_ovf_a)
			st_d.ctrl[DTC_CTRL_OVF_A] = 1'b0;
		if (ce && vec_ovf_b)
			st_d.ctrl[DTC_CTRL_OVF_B] = 1'b0;
		if (ce && vec_ext_a && st_q.ctrl[DTC_CTRL_EIT_A])
			st_d.ctrl[DTC_CTRL_EIF_A] = 1'b0;
		if (ce && vec_ext_b && st_q.ctrl[DTC_CTRL_EIT_B])
			st_d.ctrl[DTC_CTRL_EIF_B] = 1'b0;

		// Timer 0
		if (inc_a) begin
			case (md_a)
				DTC_M13: begin
					// Low five bits prescale the high byte
					if (st_q.cl0[4:0] == DTC_PRESC_MAX) begin
						st_d.cl0 = {st_q.cl0[7:5], 5'h00};
						st_d.ch0 = st_q.ch0 + 8'h01;
						ovf_a    = (st_q.ch0 == 8'hff);
					end else
						st_d.cl0 = {st_q.cl0[7:5], st_q.cl0[4:0] + 5'h01};
				end
				DTC_M16: begin
					{st_d.ch0, st_d.cl0} = {st_q.ch0, st_q.cl0} + 16'h0001;
					ovf_a = ({st_q.ch0, st_q.cl0} == 16'hffff);
				end
				DTC_MRELOAD: begin
					ovf_a    = (st_q.cl0 == 8'hff);
					st_d.cl0 = ovf_a ? st_q.ch0 : st_q.cl0 + 8'h01;
				end
				default: begin
					st_d.cl0 = st_q.cl0 + 8'h01;
					ovf_a    = (st_q.cl0 == 8'hff);
				end
			endcase
		end
		if (inc_hsplit) begin
			// Split high half borrows timer 1 overflow flag
			st_d.ch0 = st_q.ch0 + 8'h01;
			ovf_b    = (st_q.ch0 == 8'hff);
		end

		// Timer 1; mode 11 holds its value
		if (inc_b) begin
			case (md_b)
				DTC_M13: begin
					if (st_q.cl1[4:0] == DTC_PRESC_MAX) begin
						st_d.cl1 = {st_q.cl1[7:5], 5'h00};
						st_d.ch1 = st_q.ch1 + 8'h01;
						if (md_a != DTC_MSPLIT)
							ovf_b = (st_q.ch1 == 8'hff);
					end else
						st_d.cl1 = {st_q.cl1[7:5], st_q.cl1[4:0] + 5'h01};
				end
				DTC_M16: begin
					{st_d.ch1, st_d.cl1} = {st_q.ch1, st_q.cl1} + 16'h0001;
					if (md_a != DTC_MSPLIT)
						ovf_b = ({st_q.ch1, st_q.cl1} == 16'hffff);
				end
				DTC_MRELOAD: begin
					st_d.cl1 = (st_q.cl1 == 8'hff) ? st_q.ch1
						: st_q.cl1 + 8'h01;
					if (md_a != DTC_MSPLIT)
						ovf_b = (st_q.cl1 == 8'hff);
				end
				default: ;
			endcase
		end

		// Overflow set wins over any clear in the same cycle
		if (ovf_a)
			st_d.ctrl[DTC_CTRL_OVF_A] = 1'b1;
		if (ovf_b)
			st_d.ctrl[DTC_CTRL_OVF_B] = 1'b1;

		// External interrupt detection; type one is falling edge
		ext_set[0] = st_q.ctrl[DTC_CTRL_EIT_A]
			? (st_q.pin_eip[0] && !ext_pin[0]) : !ext_pin[0];
		ext_set[1] = st_q.ctrl[DTC_CTRL_EIT_B]
			? (st_q.pin_eip[1] && !ext_pin[1]) : !ext_pin[1];
		if (ce) begin
			if (ext_set[0])
				st_d.ctrl[DTC_CTRL_EIF_A] = 1'b1;
			else if (!st_q.ctrl[DTC_CTRL_EIT_A])
				st_d.ctrl[DTC_CTRL_EIF_A] = 1'b0;
			if (ext_set[1])
				st_d.ctrl[DTC_CTRL_EIF_B] = 1'b1;
			else if (!st_q.ctrl[DTC_CTRL_EIT_B])
				st_d.ctrl[DTC_CTRL_EIF_B] = 1'b0;
			st_d.pin_eip = ext_pin;
			st_d.pin_cnt = cnt_pin;
		end

		// Read data; unmapped addresses read as all ones
		if (ce && reg_rd) begin
			case (reg_addr)
				DTC_ADDR_CTRL:  st_d.rdata = st_q.ctrl;
				DTC_ADDR_MODE:  st_d.rdata = st_q.mode;
				DTC_ADDR_CL0:   st_d.rdata = st_q.cl0;
				DTC_ADDR_CL1:   st_d.rdata = st_q.cl1;
				DTC_ADDR_CH0:   st_d.rdata = st_q.ch0;
				DTC_ADDR_CH1:   st_d.rdata = st_q.ch1;
				DTC_ADDR_CKDIV: st_d.rdata = st_q.ckdiv;
				default:        st_d.rdata = 8'hff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q       <= '0;
			st_q.ckdiv <= DTC_CKDIV_RST;
			st_q.pin_eip <= 2'b11;
			st_q.pin_cnt <= 2'b11;
		end else
			st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		reg_rdata      = st_q.rdata;
		ovf_flag_a     = st_q.ctrl[DTC_CTRL_OVF_A];
		ovf_flag_b     = st_q.ctrl[DTC_CTRL_OVF_B];
		ext_irq_flag_a = st_q.ctrl[DTC_CTRL_EIF_A];
		ext_irq_flag_b = st_q.ctrl[DTC_CTRL_EIF_B];
		// Watchdog reset comes 512 clocks after its interrupt
		wdog_interval  = st_q.ckdiv[DTC_CK_WD_LO +: 2];
		clk_div_sel_c  = st_q.ckdiv[DTC_CK_SEL_C];
		// On-chip SRAM ignores the stretch field
		movx_cycles    = xram_onchip ? DTC_MC_BASE
			: DTC_MC_BASE + {1'b0, st_q.ckdiv[DTC_CK_STR_LO +: 3]};
	end
endmodule : dtc_core

// [dtc_chk.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port-level checks for the timer block
// ----------------------------------------------------------------
module dtc_chk (
	input wire logic       clk,            // Core clock
	input wire logic       nrst,           // Async reset, active low
	input wire logic       ce,             // Clock enable
	input wire logic [7:0] reg_addr,       // Register address
	input wire logic       reg_wr,         // Byte write
	input wire logic       reg_rd,         // Read strobe
	input wire logic [7:0] reg_wdata,      // Write data
	input wire logic [7:0] reg_rdata,      // Read data
	input wire logic       bit_wr,         // Bit write
	input wire logic [2:0] bit_sel,        // Bit index
	input wire logic       bit_val,        // Bit value
	input wire logic       ext_irq_pin_a,  // Interrupt pin 0
	input wire logic       vec_ext_a,      // Vectoring to ext 0
	input wire logic       xram_onchip,    // On-chip access
	input wire logic       ovf_flag_a,     // Overflow 0
	input wire logic       ovf_flag_b,     // Overflow 1
	input wire logic       ext_irq_flag_a, // External flag 0
	input wire logic       ext_irq_flag_b, // External flag 1
	input wire logic [1:0] wdog_interval,  // Watchdog code
	input wire logic       clk_div_sel_c,  // Timer 2 select
	input wire logic [3:0] movx_cycles     // Access length
);
	logic type_a_q; // Shadow of ext_irq_type_a
	wire  ctl_wr  = ce && reg_wr && reg_addr == 8'h88; // Byte write to control
	wire  ctl_any = ctl_wr || (ce && bit_wr);          // Any control write

	// ----------------------------------------------------------------
	// Shadow of the type bit; bit write wins as in the design
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) type_a_q <= 1'b0;
		else if (ce && bit_wr && bit_sel == 3'h0) type_a_q <= bit_val;
		else if (ctl_wr) type_a_q <= reg_wdata[0];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Sequences and assertions
	// ----------------------------------------------------------------
	sequence s_ck_wr;
		ce && reg_wr && reg_addr == 8'h8e;
	endsequence
	sequence s_ctl_rd;
		ce && reg_rd && reg_addr == 8'h88 && !ctl_any;
	endsequence

	chk_movx_chip: assert property (xram_onchip |-> movx_cycles == 4'h2)
		else $error("on-chip access length wrong");
	chk_movx_len: assert property (s_ck_wr ##1 !xram_onchip |->
		movx_cycles == 4'h2 + $past(reg_wdata[2:0]))
		else $error("external access length wrong");
	chk_wdog_code: assert property (s_ck_wr |=> wdog_interval == $past(reg_wdata[7:6])
		&& clk_div_sel_c == $past(reg_wdata[5]))
		else $error("exported clock fields wrong");
	chk_ctl_read: assert property (s_ctl_rd |=> reg_rdata[7] == $past(ovf_flag_b)
		&& reg_rdata[5] == $past(ovf_flag_a) && reg_rdata[3] == $past(ext_irq_flag_b)
		&& reg_rdata[1] == $past(ext_irq_flag_a))
		else $error("control read lost a flag");
	chk_soft_set: assert property (ce && bit_wr && bit_sel == 3'h5 && bit_val
		|=> ovf_flag_a)
		else $error("software set of overflow lost");
	chk_level_a: assert property (ce && !type_a_q && !ctl_any
		|=> ext_irq_flag_a == !$past(ext_irq_pin_a))
		else $error("level flag does not follow pin");
	chk_edge_set: assert property (ce && $past(ce) && type_a_q && $fell(ext_irq_pin_a)
		|=> ext_irq_flag_a)
		else $error("falling edge not flagged");
	chk_edge_clr: assert property (ce && type_a_q && vec_ext_a && ext_irq_pin_a
		&& !ctl_any |=> !ext_irq_flag_a)
		else $error("edge flag not cleared on vectoring");
	chk_rd_hole: assert property (ce && reg_rd && reg_addr == 8'h8f
		|=> reg_rdata == 8'hff)
		else $error("unmapped read not all ones");
endmodule : dtc_chk

bind dtc_core dtc_chk u_chk (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .ext_irq_pin_a(ext_irq_pin_a),
	.vec_ext_a(vec_ext_a), .xram_onchip(xram_onchip), .ovf_flag_a(ovf_flag_a),
	.ovf_flag_b(ovf_flag_b), .ext_irq_flag_a(ext_irq_flag_a),
	.ext_irq_flag_b(ext_irq_flag_b), .wdog_interval(wdog_interval),
	.clk_div_sel_c(clk_div_sel_c), .movx_cycles(movx_cycles));

// [dtc_pins.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Far side: interrupt pins, count pins, CPU vectoring
// ----------------------------------------------------------------
module dtc_pins (
	input  wire logic       clk,   // Core clock
	output logic            irq_a, // Interrupt pin 0
	output logic            irq_b, // Interrupt pin 1
	output logic            cnt_a, // Count pin 0
	output logic            cnt_b, // Count pin 1
	output logic      [3:0] vec    // Vectoring pulses
);
	// Pins idle high so nothing is counted or flagged at start
	initial begin
		irq_a = 1'b1;
		irq_b = 1'b1;
		cnt_a = 1'b1;
		cnt_b = 1'b1;
		vec   = 4'h0;
	end

	// One falling edge on a count pin; hold sets slow or prompt
	task automatic cnt_pulse(input logic b, input int hold);
		@(negedge clk);
		if (b) cnt_b = 1'b0;
		else cnt_a = 1'b0;
		repeat (hold) @(negedge clk);
		cnt_a = 1'b1;
		cnt_b = 1'b1;
		repeat (hold) @(negedge clk);
	endtask : cnt_pulse

	// Drive an interrupt pin level
	task automatic set_irq(input logic b, input logic v);
		@(negedge clk);
		if (b) irq_b = v;
		else irq_a = v;
	endtask : set_irq

	// One-cycle vectoring pulse: 0,1 overflow, 2,3 external
	task automatic vector(input int k);
		@(negedge clk);
		vec[k] = 1'b1;
		@(negedge clk);
		vec[k] = 1'b0;
	endtask : vector
endmodule : dtc_pins

// [test_dual_timer_counter_ctrl.sv]
`timescale 1ns/100ps
module test_dual_timer_counter_ctrl;
	import dtc_pkg::*;
	logic       clk, nrst, ce, reg_wr, reg_rd, bit_wr, bit_val, xram_onchip;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdat, d;
	logic [2:0] bit_sel;
	logic       irq_a, irq_b, cnt_a, cnt_b, ovf_a, ovf_b, eif_a, eif_b, sel_c;
	logic [3:0] vec, movx;
	logic [1:0] wdog;
	int         bad_count, checked, seed, cyc, n, t;

	dtc_core u_dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bit_wr(bit_wr),
		.bit_sel(bit_sel), .bit_val(bit_val), .ext_irq_pin_a(irq_a), .ext_irq_pin_b(irq_b),
		.cnt_pin_a(cnt_a), .cnt_pin_b(cnt_b), .vec_ovf_a(vec[0]), .vec_ovf_b(vec[1]),
		.vec_ext_a(vec[2]), .vec_ext_b(vec[3]), .xram_onchip(xram_onchip),
		.ovf_flag_a(ovf_a), .ovf_flag_b(ovf_b), .ext_irq_flag_a(eif_a),
		.ext_irq_flag_b(eif_b), .wdog_interval(wdog), .clk_div_sel_c(sel_c),
		.movx_cycles(movx));
	dtc_pins u_pins (.clk(clk), .irq_a(irq_a), .irq_b(irq_b), .cnt_a(cnt_a),
		.cnt_b(cnt_b), .vec(vec));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// Hang guard: whole run needs about a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			$display("MISMATCH %0t timeout", $time);
			results();
		end
	end

	// ----------------------------------------------------------------
	// Tasks and expectation functions
	// ----------------------------------------------------------------
	function automatic logic [3:0] exp_movx(input logic [7:0] k, input logic onchip);
		return onchip ? 4'h2 : 4'h2 + {1'b0, k[2:0]};
	endfunction : exp_movx

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	// Read data is registered, so it is taken one cycle later
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		rdat = reg_rdata;
	endtask : rd

	task automatic bw(input logic [2:0] s, input logic v);
		@(negedge clk);
		bit_sel = s;
		bit_val = v;
		bit_wr = 1'b1;
		@(negedge clk);
		bit_wr = 1'b0;
	endtask : bw

	task automatic setup(input logic [7:0] m, k, l, h, input logic tb);
		wr(8'h88, 8'h00);
		wr(8'h89, m);
		wr(8'h8e, k);
		wr(tb ? 8'h8b : 8'h8a, l);
		wr(tb ? 8'h8d : 8'h8c, h);
	endtask : setup

	// Run a timer until overflow; first tick may come up to one period early
	task automatic ovf_time(input logic tb, input int ticks, input int div);
		int c;
		c = 0;
		bw(tb ? 3'h6 : 3'h4, 1'b1);
		while (!(tb ? ovf_b : ovf_a) && c < 2000) begin
			@(negedge clk);
			c++;
		end
		bw(tb ? 3'h6 : 3'h4, 1'b0);
		chk({7'h0, c >= (ticks - 1) * div - 1 && c <= ticks * div + 3}, 8'h1, "overflow time");
	endtask : ovf_time

	task automatic results();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 24;
		{nrst, reg_wr, reg_rd, bit_wr, bit_val, xram_onchip} = 6'h0;
		{ce, reg_addr, reg_wdata, bit_sel} = {1'b1, 19'h0};
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		chk({4'h0, movx}, 8'h03, "access length after reset");
		rd(8'h8e);
		chk(rdat, 8'h01, "clock select reset");
		rd(8'h8f);
		chk(rdat, 8'hff, "unmapped read");
		$display("test reset done");
		for (n = 0; n < 8; n++) begin
			d = 8'($random(seed));
			d[2:0] = n[2:0];
			wr(8'h8e, d);
			xram_onchip = n[0];
			#1 chk({4'h0, movx}, {4'h0, exp_movx(d, n[0])}, "access length");
			chk({5'h0, wdog, sel_c}, {5'h0, d[7:5]}, "clock fields");
		end
		for (n = 0; n < 5; n++) begin
			d = 8'($random(seed));
			wr(8'h89 + 8'(n), d);
			rd(8'h89 + 8'(n));
			chk(rdat, d, "count byte");
		end
		ce = 1'b0;
		wr(8'h8d, ~d);
		ce = 1'b1;
		rd(8'h8d);
		chk(rdat, d, "write while frozen");
		$display("test registers done");
		for (t = 0; t < 2; t++) begin
			n = 2 + ({$random(seed)} % 16);
			setup(8'h01, 8'h18, 8'(256 - n), 8'hff, 1'b0);
			ovf_time(1'b0, n, 4);
		end
		setup(8'h00, 8'h18, 8'h10, 8'hff, 1'b0);
		ovf_time(1'b0, 16, 4);
		setup(8'h10, 8'h08, 8'hf0, 8'hff, 1'b1);
		ovf_time(1'b1, 16, 12);
		setup(8'h02, 8'h18, 8'hf0, 8'h80, 1'b0);
		ovf_time(1'b0, 16, 4);
		rd(8'h8a);
		chk(rdat, 8'h80, "reload value");
		setup(8'h33, 8'h18, 8'h55, 8'hff, 1'b1);
		wr(8'h8c, 8'hf0);
		ovf_time(1'b1, 16, 4);
		rd(8'h8b);
		chk(rdat, 8'h55, "stopped timer held");
		chk({7'h0, ovf_b}, 8'h1, "split overflow flag");
		u_pins.vector(1);
		chk({7'h0, ovf_b}, 8'h0, "vectoring clear b");
		$display("test modes done");
		setup(8'h09, 8'h18, 8'hf0, 8'hff, 1'b0);
		u_pins.set_irq(1'b0, 1'b0);
		bw(3'h4, 1'b1);
		repeat (100) @(negedge clk);
		rd(8'h8a);
		chk(rdat, 8'hf0, "gated timer moved");
		u_pins.set_irq(1'b0, 1'b1);
		ovf_time(1'b0, 16, 4);
		setup(8'h05, 8'h18, 8'hfe, 8'hff, 1'b0);
		bw(3'h4, 1'b1);
		u_pins.cnt_pulse(1'b0, 3);
		chk({7'h0, ovf_a}, 8'h0, "early count overflow");
		u_pins.cnt_pulse(1'b0, 1);
		chk({7'h0, ovf_a}, 8'h1, "count overflow");
		u_pins.vector(0);
		chk({7'h0, ovf_a}, 8'h0, "vectoring clear");
		bw(3'h5, 1'b1);
		chk({7'h0, ovf_a}, 8'h1, "bit set");
		wr(8'h88, 8'h20);
		rd(8'h88);
		chk(rdat, 8'h20, "control byte");
		$display("test counting done");
		for (t = 0; t < 2; t++) begin
			wr(8'h88, 8'h05);
			u_pins.set_irq(t[0], 1'b0);
			@(negedge clk);
			chk({7'h0, t ? eif_b : eif_a}, 8'h1, "edge flag");
			u_pins.set_irq(t[0], 1'b1);
			u_pins.vector(2 + t);
			chk({7'h0, t ? eif_b : eif_a}, 8'h0, "edge vectoring");
			wr(8'h88, 8'h00);
			u_pins.set_irq(t[0], 1'b0);
			@(negedge clk);
			u_pins.vector(2 + t);
			chk({7'h0, t ? eif_b : eif_a}, 8'h1, "level flag");
			u_pins.set_irq(t[0], 1'b1);
			@(negedge clk);
			chk({7'h0, t ? eif_b : eif_a}, 8'h0, "level follows pin");
		end
		$display("test interrupts done");
		results();
	end
endmodule : test_dual_timer_counter_ctrl
